// ===== core/apm_pkg.sv
// shared constants for the amplifier protection and fault monitor
package apm_pkg;
    localparam int NUM_CH = 4;
    // register addresses and bit positions of the control fields
    localparam logic [7:0] MISC_CTRL_ADDR = 8'h01;
    localparam int CAP_LEVEL_BIT = 4;
    localparam int OTW_SEL_LO_BIT = 5;
    localparam int OTW_SEL_HI_BIT = 6;
    localparam logic [7:0] CLR_FAULT_ADDR = 8'h21;
    localparam int CLR_FAULT_BIT = 7;
    // clipping: consecutive full-duty pwm clocks before the flag is raised
    localparam logic [4:0] CLIP_PWM_CLOCKS = 5'h14;
    // diagnostic retry period and standby ramp-down time
    localparam int CLK_MHZ = 100;
    localparam int RETRY_PERIOD_MS = 1000;
    localparam int RAMP_DOWN_MS = 5;
    localparam int RETRY_CYCLES = RETRY_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int RAMP_CYCLES = RAMP_DOWN_MS * 1000 * CLK_MHZ;
    // mask reset values: everything unmasked
    localparam logic [4:0] FAULT_MASK_RST = 5'h00;
    localparam logic [1:0] WARN_MASK_RST = 2'h0;
    // requested channel states
    localparam logic [1:0] CH_FLOAT = 2'h0;
    localparam logic [1:0] CH_MUTE = 2'h1;
    localparam logic [1:0] CH_PLAY = 2'h2;
    // per-channel protection state
    typedef enum logic [3:0] {
        APM_RUN = 4'b0001,
        APM_TRIP = 4'b0010,
        APM_DIAG = 4'b0100,
        APM_WAIT = 4'b1000
    } apm_ch_e;
endpackage

// ===== core/apm_channel.sv
// one output channel: overcurrent shutdown, diagnostic retry, dc detect, clip, channel thermal
`timescale 1ns/100ps
module apm_channel
    import apm_pkg::*;
#(
    parameter int RETRY_CYC = RETRY_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // analog comparator results
    input wire logic over_cap_i,
    input wire logic over_trip_i,
    input wire logic dc_offset_i,
    input wire logic full_duty_i,
    input wire logic pwm_tick_i,
    input wire logic ch_warn_i,
    input wire logic ch_shut_i,
    // diagnostics engine
    input wire logic diag_en_i,
    input wire logic diag_done_i,
    input wire logic diag_fail_i,
    input wire logic clear_i,
    // results
    output logic pulse_cut_o,
    output logic floating_o,
    output logic diag_start_o,
    output logic oc_fault_o,
    output logic dc_fault_o,
    output logic clip_o,
    output logic ot_warn_o,
    output logic ot_shut_o
);
    apm_ch_e state_r;
    logic [31:0] wait_cnt_r;
    logic [4:0] clip_cnt_r;
    logic dc_lat_r;

    // pulse termination only; no status side effect
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_cut_o <= 1'b0;
        end else begin
            pulse_cut_o <= over_cap_i && !over_trip_i;
        end
    end

    // overcurrent trip and hiccup retry through the diagnostics
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= APM_RUN;
            wait_cnt_r <= 32'h0;
            diag_start_o <= 1'b0;
        end else begin
            diag_start_o <= 1'b0;
            case (state_r)
                APM_RUN: begin
                    if (over_trip_i) begin
                        state_r <= APM_TRIP;
                    end
                end
                APM_TRIP: begin
                    if (diag_en_i) begin
                        state_r <= APM_DIAG;
                        diag_start_o <= 1'b1;
                    end
                    // without diagnostics the channel stays floating for the host
                end
                APM_DIAG: begin
                    if (diag_done_i) begin
                        if (diag_fail_i) begin
                            state_r <= APM_WAIT;
                            wait_cnt_r <= 32'h0;
                        end else begin
                            state_r <= APM_RUN;
                        end
                    end
                end
                APM_WAIT: begin
                    if (wait_cnt_r == 32'(RETRY_CYC - 1)) begin
                        state_r <= APM_DIAG;
                        diag_start_o <= 1'b1;
                    end else begin
                        wait_cnt_r <= wait_cnt_r + 32'h1;
                    end
                end
                default: state_r <= APM_RUN;
            endcase
        end
    end

    // sticky oc, dc and clip status, set beats clear; thermal warning follows its input
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            oc_fault_o <= 1'b0;
            dc_fault_o <= 1'b0;
            dc_lat_r <= 1'b0;
            clip_o <= 1'b0;
            clip_cnt_r <= 5'h0;
            ot_warn_o <= 1'b0;
            ot_shut_o <= 1'b0;
        end else begin
            oc_fault_o <= (over_trip_i || state_r != APM_RUN) ? 1'b1 : (clear_i ? 1'b0 : oc_fault_o);
            dc_lat_r <= dc_offset_i ? 1'b1 : (clear_i ? 1'b0 : dc_lat_r);
            dc_fault_o <= dc_offset_i || dc_lat_r;
            if (!full_duty_i) begin
                clip_cnt_r <= 5'h0;
            end else if (pwm_tick_i && clip_cnt_r != CLIP_PWM_CLOCKS) begin
                clip_cnt_r <= clip_cnt_r + 5'h1;
            end
            if (clip_cnt_r == CLIP_PWM_CLOCKS) begin
                clip_o <= 1'b1;
            end else if (clear_i) begin
                clip_o <= 1'b0;
            end
            ot_warn_o <= ch_warn_i;
            // hold the shutdown until cooled below the warning level
            if (ch_shut_i) begin
                ot_shut_o <= 1'b1;
            end else if (!ch_warn_i) begin
                ot_shut_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            floating_o <= 1'b1;
        end else begin
            floating_o <= over_trip_i || state_r != APM_RUN || dc_offset_i || dc_lat_r
                || ch_shut_i || ot_shut_o;
        end
    end
endmodule

// ===== core/apm_top.sv
// amplifier protection and fault monitor, four channels, pin level reporting
// Functional notes
// - each channel cuts pulses above current cap
// - pulse capping sets no fault nor pin
// - control bit 4 selects cap/trip level
// - trip level floats channel, records, asserts fault
// - diagnostics on: retest, restart, else retry 1s
// - diagnostics off: channel stays floating for host
// - dc offset floats channel, records, pin unless masked
// - clip after 20 full-duty pwm clocks, warn pin
// - clip flag sticky until clear-fault written
// - bits 5-6 choose four global warn levels
// - over warning level drives warn pin unmasked
// - thermal shutdown floats all, restores when cool
// - per-channel thermal warning bit and pin
// - channel shutdown floats until below warning
// - supply undervoltage drives fault and status
// - power-on reset clears, then sets por warning
// - supply overvoltage drives fault and status
// - fault pin low while any fault condition
// - fault masks gate pin only; reset unmasked
// - warn masks gate pin only; pin latched
// - mute pin low mutes all channels
// - standby: ramp down within 5 ms, float i2c
`timescale 1ns/100ps
module apm_top
    import apm_pkg::*;
#(
    parameter int RETRY_CYC = RETRY_CYCLES,
    parameter int RAMP_CYC = RAMP_CYCLES
) (
    // clock and reset (reset is the logic-supply power-on reset)
    input wire logic clk_i,
    input wire logic rst_i,
    // register contents from the control interface
    input wire logic [7:0] misc_ctrl_i,
    input wire logic clear_fault_i,
    input wire logic [4:0] fault_mask_i,
    input wire logic [1:0] warn_mask_i,
    input wire logic [7:0] ch_state_req_i,
    input wire logic diag_en_i,
    // per-channel comparators
    input wire logic [3:0] over_cap_i,
    input wire logic [3:0] over_trip_i,
    input wire logic [3:0] dc_offset_i,
    input wire logic [3:0] full_duty_i,
    input wire logic pwm_tick_i,
    input wire logic [3:0] ch_warn_i,
    input wire logic [3:0] ch_shut_i,
    // diagnostics engine
    input wire logic [3:0] diag_done_i,
    input wire logic [3:0] diag_fail_i,
    // global monitors
    input wire logic [3:0] temp_warn_lvl_i,
    input wire logic temp_shut_i,
    input wire logic output_stage_supply_too_low_i,
    input wire logic battery_supply_too_low_i,
    input wire logic output_stage_supply_too_high_i,
    input wire logic clock_error_i,
    // host pins
    input wire logic mute_n_i,
    input wire logic standby_n_i,
    // limiter and level select
    output logic [3:0] pulse_current_cap_o,
    output logic trip_level_sel_o,
    // channel control
    output logic [3:0] outputs_floating_state_o,
    output logic [7:0] ch_state_o,
    output logic [3:0] diag_start_o,
    output logic ramp_down_o,
    output logic i2c_float_o,
    // status register bits
    output logic [3:0] oc_fault_o,
    output logic [3:0] dc_fault_o,
    output logic [3:0] clip_o,
    output logic [3:0] channel_overtemp_warning_o,
    output logic [3:0] channel_overtemp_shutdown_o,
    output logic overtemp_warning_o,
    output logic overtemp_shutdown_o,
    output logic supply_too_low_o,
    output logic supply_too_high_o,
    output logic por_warn_o,
    // open-drain pins: enable high pulls low
    output logic fault_n_o,
    output logic fault_oe_o,
    output logic warn_n_o,
    output logic warn_oe_o
);
    logic [3:0] cut_w, float_w, start_w, oc_w, dc_w, clip_w, cw_w, cs_w;
    logic [31:0] ramp_cnt_r;
    logic warn_lat_r;
    logic fault_any;
    logic warn_any;
    logic warn_lat_nxt;
    logic clr_w;

    assign clr_w = clear_fault_i;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            apm_channel #(
                .RETRY_CYC(RETRY_CYC)
            ) u_ch (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .over_cap_i(over_cap_i[g]),
                .over_trip_i(over_trip_i[g]),
                .dc_offset_i(dc_offset_i[g]),
                .full_duty_i(full_duty_i[g]),
                .pwm_tick_i(pwm_tick_i),
                .ch_warn_i(ch_warn_i[g]),
                .ch_shut_i(ch_shut_i[g]),
                .diag_en_i(diag_en_i),
                .diag_done_i(diag_done_i[g]),
                .diag_fail_i(diag_fail_i[g]),
                .clear_i(clr_w),
                .pulse_cut_o(cut_w[g]),
                .floating_o(float_w[g]),
                .diag_start_o(start_w[g]),
                .oc_fault_o(oc_w[g]),
                .dc_fault_o(dc_w[g]),
                .clip_o(clip_w[g]),
                .ot_warn_o(cw_w[g]),
                .ot_shut_o(cs_w[g])
            );
        end
    endgenerate

    // per-channel status and controls, registered once more so outputs are flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_current_cap_o <= 4'h0;
            diag_start_o <= 4'h0;
            oc_fault_o <= 4'h0;
            dc_fault_o <= 4'h0;
            clip_o <= 4'h0;
            channel_overtemp_warning_o <= 4'h0;
            channel_overtemp_shutdown_o <= 4'h0;
            trip_level_sel_o <= 1'b0;
        end else begin
            pulse_current_cap_o <= cut_w;
            diag_start_o <= start_w;
            oc_fault_o <= oc_w;
            dc_fault_o <= dc_w;
            clip_o <= clip_w;
            channel_overtemp_warning_o <= cw_w;
            channel_overtemp_shutdown_o <= cs_w;
            trip_level_sel_o <= misc_ctrl_i[CAP_LEVEL_BIT];
        end
    end

    // global monitors; warning level chosen from four comparators
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            overtemp_warning_o <= 1'b0;
            overtemp_shutdown_o <= 1'b0;
            supply_too_low_o <= 1'b0;
            supply_too_high_o <= 1'b0;
        end else begin
            overtemp_warning_o <=
                temp_warn_lvl_i[misc_ctrl_i[OTW_SEL_HI_BIT:OTW_SEL_LO_BIT]];
            overtemp_shutdown_o <= temp_shut_i;
            supply_too_low_o <= output_stage_supply_too_low_i
                || battery_supply_too_low_i;
            supply_too_high_o <= output_stage_supply_too_high_i;
        end
    end

    // por warning: cleared only by the reset itself, raised once the bus is back
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            por_warn_o <= 1'b0;
        end else if (!i2c_float_o) begin
            por_warn_o <= 1'b1;
        end
    end

    // standby ramp-down timer; i2c floats while in standby or reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ramp_cnt_r <= 32'h0;
            ramp_down_o <= 1'b0;
            i2c_float_o <= 1'b1;
        end else begin
            i2c_float_o <= !standby_n_i;
            if (standby_n_i) begin
                ramp_cnt_r <= 32'h0;
                ramp_down_o <= 1'b0;
            end else if (ramp_cnt_r != 32'(RAMP_CYC - 1)) begin
                ramp_cnt_r <= ramp_cnt_r + 32'h1;
                ramp_down_o <= 1'b1;
            end else begin
                ramp_down_o <= 1'b0;
            end
        end
    end

    // channel state: floating (faults, or standby once ramped down) wins, then mute, else requested
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            outputs_floating_state_o <= 4'hf;
            ch_state_o <= 8'h00;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (float_w[i] || temp_shut_i || output_stage_supply_too_low_i
                    || battery_supply_too_low_i || output_stage_supply_too_high_i
                    || (!standby_n_i && ramp_cnt_r == 32'(RAMP_CYC - 1))) begin
                    outputs_floating_state_o[i] <= 1'b1;
                    ch_state_o[2*i +: 2] <= CH_FLOAT;
                end else begin
                    outputs_floating_state_o[i] <= ch_state_req_i[2*i +: 2] == CH_FLOAT;
                    if (!mute_n_i && ch_state_req_i[2*i +: 2] == CH_PLAY) begin
                        ch_state_o[2*i +: 2] <= CH_MUTE;
                    end else begin
                        ch_state_o[2*i +: 2] <= ch_state_req_i[2*i +: 2];
                    end
                end
            end
        end
    end

    // fault pin follows sticky channel flags and live global conditions through category masks
    always_comb begin
        fault_any = ((|oc_w || |dc_w) && !fault_mask_i[0])
            || (temp_shut_i && !fault_mask_i[1])
            || ((output_stage_supply_too_low_i || battery_supply_too_low_i)
                && !fault_mask_i[2])
            || (output_stage_supply_too_high_i && !fault_mask_i[3])
            || (clock_error_i && !fault_mask_i[4]);
        // a sticky clip flag being cleared must not re-arm the pin in that cycle
        warn_any = (|clip_w && !clr_w && !warn_mask_i[0])
            || ((overtemp_warning_o || |cw_w) && !warn_mask_i[1])
            || (!por_warn_o && !i2c_float_o);
        warn_lat_nxt = warn_any || (warn_lat_r && !clr_w);
    end

    // warn pin latched until clear; a new event in the clear cycle wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            warn_lat_r <= 1'b0;
            fault_n_o <= 1'b1;
            fault_oe_o <= 1'b0;
            warn_n_o <= 1'b1;
            warn_oe_o <= 1'b0;
        end else begin
            warn_lat_r <= warn_lat_nxt;
            fault_n_o <= !fault_any;
            fault_oe_o <= fault_any;
            warn_n_o <= !warn_lat_nxt;
            warn_oe_o <= warn_lat_nxt;
        end
    end
endmodule

// ===== tb/apm_host_model.sv
// host-side partner: pull-ups on the status pins and a diagnostics responder
`timescale 1ns/100ps
module apm_host_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // device pins and diagnostic requests
    input wire logic fault_oe_i,
    input wire logic warn_oe_i,
    input wire logic [3:0] diag_start_i,
    input wire logic fail_first_i,
    // resolved pin levels and diagnostic results
    output logic fault_pin_o,
    output logic warn_pin_o,
    output logic [3:0] diag_done_o,
    output logic [3:0] diag_fail_o
);
    logic [3:0] tried_r;
    logic [3:0] dly1_r;
    logic [3:0] dly2_r;
    // internal pull-ups win whenever nobody pulls low
    assign fault_pin_o = fault_oe_i ? 1'b0 : 1'b1;
    assign warn_pin_o = warn_oe_i ? 1'b0 : 1'b1;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tried_r <= 4'h0;
            dly1_r <= 4'h0;
            dly2_r <= 4'h0;
            diag_done_o <= 4'h0;
            diag_fail_o <= 4'h0;
        end else begin
            dly1_r <= diag_start_i;
            dly2_r <= dly1_r;
            diag_done_o <= dly2_r;
            // only the first run of a channel may find a load fault
            diag_fail_o <= dly2_r & ~tried_r & {4{fail_first_i}};
            tried_r <= tried_r | dly2_r;
        end
    end
endmodule

// ===== tb/apm_top_chk.sv
// concurrent checks on the ports of the protection and fault monitor
`timescale 1ns/100ps
module apm_top_chk
    import apm_pkg::*;
#(
    parameter int RAMP_CYC = RAMP_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic [7:0] misc_ctrl_i,
    input wire logic clear_fault_i,
    input wire logic [4:0] fault_mask_i,
    input wire logic [3:0] over_cap_i,
    input wire logic [3:0] over_trip_i,
    input wire logic [3:0] dc_offset_i,
    input wire logic temp_shut_i,
    input wire logic battery_supply_too_low_i,
    input wire logic output_stage_supply_too_high_i,
    input wire logic mute_n_i,
    input wire logic standby_n_i,
    // watched outputs
    input wire logic [3:0] pulse_current_cap_o,
    input wire logic trip_level_sel_o,
    input wire logic [3:0] outputs_floating_state_o,
    input wire logic [7:0] ch_state_o,
    input wire logic i2c_float_o,
    input wire logic [3:0] oc_fault_o,
    input wire logic [3:0] dc_fault_o,
    input wire logic supply_too_low_o,
    input wire logic supply_too_high_o,
    input wire logic fault_oe_o,
    input wire logic warn_oe_o
);
    // ramp counter plus register and pin stages
    localparam int RAMP_LIM = RAMP_CYC + 4;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_cap_follows: assert property (over_cap_i != 4'h0 |-> ##[1:2]
        pulse_current_cap_o != 4'h0) else $error("pulse cap not raised");
    chk_level_sel: assert property ($stable(misc_ctrl_i[4]) [*2] |->
        trip_level_sel_o == misc_ctrl_i[4]) else $error("level select wrong");
    chk_trip_floats: assert property ($rose(over_trip_i[0]) |-> ##2
        (oc_fault_o[0] && outputs_floating_state_o[0])) else $error("trip not handled");
    chk_dc_floats: assert property ($rose(dc_offset_i[3]) |-> ##2
        (dc_fault_o[3] && outputs_floating_state_o[3])) else $error("dc offset not handled");
    chk_shut_pin: assert property (temp_shut_i && !fault_mask_i[1] |=> fault_oe_o)
        else $error("fault pin not driven on shutdown");
    chk_uv_status: assert property (battery_supply_too_low_i |=> supply_too_low_o)
        else $error("undervoltage status missing");
    chk_ov_pin: assert property (output_stage_supply_too_high_i && !fault_mask_i[3] |=>
        fault_oe_o && supply_too_high_o) else $error("overvoltage not reported");
    chk_warn_hold: assert property (warn_oe_o && !clear_fault_i |=> warn_oe_o)
        else $error("warn pin released without clear");
    chk_mute_state: assert property (!mute_n_i [*3] |-> ch_state_o[1:0] != CH_PLAY)
        else $error("channel plays while muted");
    chk_stby_float: assert property ($fell(standby_n_i) |-> ##[1:RAMP_LIM]
        (i2c_float_o && outputs_floating_state_o == 4'hf)) else $error("standby not reached");
endmodule

// ===== tb/apm_top_bench.sv
// self-checking bench for the protection and fault monitor
`timescale 1ns/100ps
module apm_top_bench;
    import apm_pkg::*;
    localparam int RETRY = 50;
    localparam int RAMP = 20;
    logic clk_i = 1'b0, rst_i = 1'b1, clear_fault_i = 1'b0, diag_en_i = 1'b0;
    logic [7:0] misc_ctrl_i = 8'h00, ch_state_req_i = 8'haa;
    logic [4:0] fault_mask_i = 5'h00;
    logic [1:0] warn_mask_i = 2'h0;
    logic [3:0] over_cap_i = 4'h0, over_trip_i = 4'h0, dc_offset_i = 4'h0;
    logic [3:0] full_duty_i = 4'h0, ch_warn_i = 4'h0, ch_shut_i = 4'h0, temp_warn_lvl_i = 4'h0;
    logic pwm_tick_i = 1'b0, temp_shut_i = 1'b0, fail_first = 1'b1;
    logic [3:0] sup = 4'h0;
    logic mute_n_i = 1'b1, standby_n_i = 1'b1;
    logic [3:0] diag_done, diag_fail, cap, flt, dstart, ocf, dcf, clip, cotw, cotsd;
    logic [7:0] ch_state;
    logic lvl, ramp, i2cf, overtemp_warning, overtemp_shutdown, uv, ov, por, foe, woe, fault_pin, warn_pin;
    int n_mismatch = 0, cmp_count = 0, n;
    `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
    always #5 clk_i = ~clk_i;
    apm_top #(.RETRY_CYC(RETRY), .RAMP_CYC(RAMP)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .misc_ctrl_i(misc_ctrl_i), .clear_fault_i(clear_fault_i), .fault_mask_i(fault_mask_i),
        .warn_mask_i(warn_mask_i), .ch_state_req_i(ch_state_req_i), .diag_en_i(diag_en_i),
        .over_cap_i(over_cap_i), .over_trip_i(over_trip_i), .dc_offset_i(dc_offset_i),
        .full_duty_i(full_duty_i), .pwm_tick_i(pwm_tick_i), .ch_warn_i(ch_warn_i),
        .ch_shut_i(ch_shut_i), .diag_done_i(diag_done), .diag_fail_i(diag_fail),
        .temp_warn_lvl_i(temp_warn_lvl_i), .temp_shut_i(temp_shut_i),
        .output_stage_supply_too_low_i(sup[0]), .battery_supply_too_low_i(sup[1]),
        .output_stage_supply_too_high_i(sup[2]), .clock_error_i(sup[3]),
        .mute_n_i(mute_n_i), .standby_n_i(standby_n_i), .pulse_current_cap_o(cap),
        .trip_level_sel_o(lvl), .outputs_floating_state_o(flt), .ch_state_o(ch_state),
        .diag_start_o(dstart), .ramp_down_o(ramp), .i2c_float_o(i2cf), .oc_fault_o(ocf),
        .dc_fault_o(dcf), .clip_o(clip), .channel_overtemp_warning_o(cotw),
        .channel_overtemp_shutdown_o(cotsd), .overtemp_warning_o(overtemp_warning), .overtemp_shutdown_o(overtemp_shutdown),
        .supply_too_low_o(uv), .supply_too_high_o(ov), .por_warn_o(por), .fault_n_o(),
        .fault_oe_o(foe), .warn_n_o(), .warn_oe_o(woe));
    apm_host_model host_u (.clk_i(clk_i), .rst_i(rst_i), .fault_oe_i(foe), .warn_oe_i(woe),
        .diag_start_i(dstart), .fail_first_i(fail_first), .fault_pin_o(fault_pin),
        .warn_pin_o(warn_pin), .diag_done_o(diag_done), .diag_fail_o(diag_fail));
    task automatic complete_run;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // inputs always change 1 ns after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic clear;
        clear_fault_i = 1'b1;
        step(1);
        clear_fault_i = 1'b0;
        step(2);
    endtask
    task automatic tick;
        pwm_tick_i = 1'b1;
        step(1);
        pwm_tick_i = 1'b0;
        step(1);
    endtask
    // bounded wait for a diagnostic start on channel c
    task automatic wait_start(input int c, input int lim);
        n = 0;
        while (dstart[c] !== 1'b1) begin
            step(1);
            n++;
            if (n > lim) begin
                n_mismatch++;
                complete_run();
            end
        end
    endtask
    initial begin
        step(5);
        `CHK("rst_float", 4'hf, flt)
        `CHK("rst_i2c", 1'b1, i2cf)
        step(5);
        rst_i = 1'b0;
        step(3);
        `CHK("por_warn", 1'b1, por)
        `CHK("por_pin", 1'b0, warn_pin)
        clear;
        mute_n_i = 1'b0;
        step(3);
        `CHK("muted", 8'h55, ch_state)
        mute_n_i = 1'b1;
        step(3);
        `CHK("unmuted", 8'haa, ch_state)
        for (int s = 0; s < 4; s++) begin
            misc_ctrl_i[6:5] = s[1:0];
            temp_warn_lvl_i = ~(4'h1 << s);
            step(3);
            `CHK("otw_off", 1'b0, overtemp_warning)
            `CHK("otw_rel", 1'b1, warn_pin)
            temp_warn_lvl_i = 4'h1 << s;
            step(3);
            `CHK("otw_on", 1'b1, overtemp_warning)
            `CHK("otw_pin", 1'b0, warn_pin)
            temp_warn_lvl_i = 4'h0;
            step(1);
            clear;
        end
        temp_shut_i = 1'b1;
        step(3);
        `CHK("overtemp_shutdown_float", 4'hf, flt)
        `CHK("overtemp_shutdown_pin", 1'b0, fault_pin)
        `CHK("overtemp_shutdown_stat", 1'b1, overtemp_shutdown)
        temp_shut_i = 1'b0;
        step(3);
        `CHK("overtemp_shutdown_back", 4'h0, flt)
        ch_warn_i = 4'h4;
        ch_shut_i = 4'h4;
        step(3);
        `CHK("chsd_float", 4'h4, flt)
        `CHK("chsd_stat", 1'b1, cotsd[2])
        `CHK("chw_stat", 1'b1, cotw[2])
        `CHK("chw_pin", 1'b0, warn_pin)
        ch_shut_i = 4'h0;
        step(3);
        `CHK("chsd_hold", 4'h4, flt)
        ch_warn_i = 4'h0;
        step(3);
        `CHK("chsd_back", 4'h0, flt)
        clear;
        misc_ctrl_i[4] = 1'b1;
        over_cap_i = 4'h4;
        step(3);
        `CHK("cap", 4'h4, cap)
        `CHK("lvl_hi", 1'b1, lvl)
        `CHK("cap_stat", 4'h0, ocf)
        `CHK("cap_pin", 1'b1, fault_pin)
        over_cap_i = 4'h0;
        misc_ctrl_i[4] = 1'b0;
        step(2);
        `CHK("lvl_lo", 1'b0, lvl)
        for (int k = 0; k < 4; k++) begin
            sup = 4'h1 << k;
            step(2);
            `CHK("sup_pin", 1'b0, fault_pin)
            `CHK("uv_stat", k < 2, uv)
            `CHK("ov_stat", k == 2, ov)
            sup = 4'h0;
            step(2);
            `CHK("sup_free", 1'b1, fault_pin)
            clear;
        end
        for (int m = 1; m >= 0; m--) begin
            warn_mask_i = {1'b0, m[0]};
            full_duty_i = 4'h1;
            repeat (CLIP_PWM_CLOCKS - 1) tick;
            step(3);
            `CHK("clip_early", 1'b0, clip[0])
            tick;
            step(3);
            `CHK("clip_set", 1'b1, clip[0])
            `CHK("clip_pin", m[0], warn_pin)
            full_duty_i = 4'h0;
            step(3);
            `CHK("clip_sticky", 1'b1, clip[0])
            `CHK("clip_latch", m[0], warn_pin)
            clear;
            `CHK("clip_clr", 1'b0, clip[0])
            `CHK("pin_clr", 1'b1, warn_pin)
        end
        fault_mask_i = 5'h01;
        dc_offset_i = 4'h8;
        step(3);
        `CHK("dc_stat", 1'b1, dcf[3])
        `CHK("dc_float", 1'b1, flt[3])
        `CHK("dc_masked", 1'b1, fault_pin)
        fault_mask_i = 5'h00;
        step(2);
        `CHK("dc_pin", 1'b0, fault_pin)
        dc_offset_i = 4'h0;
        clear;
        over_trip_i = 4'h1;
        step(1);
        over_trip_i = 4'h0;
        step(2);
        `CHK("oc_stat", 1'b1, ocf[0])
        `CHK("oc_float", 1'b1, flt[0])
        `CHK("oc_pin", 1'b0, fault_pin)
        n = 0;
        repeat (RETRY + 10) begin
            step(1);
            if (dstart[0] === 1'b1)
                n++;
        end
        `CHK("no_diag", 0, n)
        `CHK("oc_stays", 1'b1, flt[0])
        diag_en_i = 1'b1;
        over_trip_i = 4'h2;
        step(1);
        over_trip_i = 4'h0;
        wait_start(1, 10);
        step(1);
        wait_start(1, RETRY + 20);
        `CHK("retry_gap", 1'b1, n >= RETRY)
        step(10);
        `CHK("restart", 1'b0, flt[1])
        standby_n_i = 1'b0;
        step(3);
        `CHK("stby_i2c", 1'b1, i2cf)
        `CHK("stby_ramp", 1'b1, ramp)
        step(RAMP + 5);
        `CHK("stby_float", 4'hf, flt)
        complete_run();
    end
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule
bind apm_top apm_top_chk #(.RAMP_CYC(RAMP_CYC)) chk_u (.clk_i, .rst_i, .misc_ctrl_i,
    .clear_fault_i, .fault_mask_i, .over_cap_i, .over_trip_i, .dc_offset_i, .temp_shut_i,
    .battery_supply_too_low_i, .output_stage_supply_too_high_i, .mute_n_i, .standby_n_i,
    .pulse_current_cap_o, .trip_level_sel_o, .outputs_floating_state_o, .ch_state_o,
    .i2c_float_o, .oc_fault_o, .dc_fault_o, .supply_too_low_o, .supply_too_high_o,
    .fault_oe_o, .warn_oe_o);
